// ### hdl/spimsp_pkg.sv
/*
 * Constants, types and carriers shared by the serial port unit and its buffer.
 * Assumes a single 50 MHz peripheral clock and a synchronous active-high reset.
 */
package spimsp_pkg;

	localparam int             DATA_W      = 8;
	localparam int             RXBUF_DEPTH = 2;
	localparam int             CLK_HZ      = 50_000_000;
	localparam logic [7:0]     SREG_RST    = 8'h00;
	localparam logic [3:0]     LAST_PHASE  = 4'hF;
	localparam logic [3:0]     LAST_BIT    = 4'h7;
	localparam logic [3:0]     BIT_COUNT   = 4'h8;
	// Master clock divisors selected by the prescaler field; double speed halves them.
	localparam logic [7:0]     PRESC_DIV [4] = '{8'h04, 8'h10, 8'h40, 8'h80};

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_LEAD  = 2'b01,
		ST_SHIFT = 2'b10
	} spimsp_state_t;

	typedef struct packed {
		logic       enable;
		logic       bufMode;
		logic       lsbFirst;
		logic       clk2x;
		logic [1:0] presc;
		logic       ssDisable;
	} spimsp_cfg_t;

	// Port direction set by software, one means output.
	typedef struct packed {
		logic mosi;
		logic miso;
		logic sck;
		logic ss;
	} spimsp_dir_t;

	typedef struct packed {
		logic out;
		logic oe;
	} spimsp_pin_t;

endpackage

// ### hdl/spimsp_buf.sv
/*
 * Small FIFO with valid and ready on both sides, used as the receive buffer.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module spimsp_buf
	import spimsp_pkg::*;
#(
	parameter int WIDTH = DATA_W,
	parameter int DEPTH = RXBUF_DEPTH
) (
	// Clock and reset.
	input  wire logic             clock,
	input  wire logic             rst,
	// Filling side.
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// Draining side.
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	if (WIDTH < 1 || DEPTH < 2) begin : g_check
		$error("spimsp_buf needs WIDTH of at least 1 and DEPTH of at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wrPtr_r;
	logic [PW-1:0]    rdPtr_r;
	logic [PW:0]      count_r;
	wire              push = inValid && inReady;
	wire              pop  = outValid && outReady;

	assign inReady  = (count_r != (PW+1)'(DEPTH));
	assign outValid = (count_r != '0);
	assign outData  = mem[rdPtr_r];

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wrPtr_r] <= inData;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wrPtr_r <= (wrPtr_r == PW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
			end
			if (pop) begin
				rdPtr_r <= (rdPtr_r == PW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
			end
			count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

endmodule

// ### hdl/spimsp_top.sv
/*
 * Master or slave serial peripheral port with one 8-bit shift register,
 * normal and buffered data modes, pin direction overrides and debug halt.
 * Assumes pin inputs synchronous to the clock except the slave serial clock,
 * which is resynchronised here; the software side is a set of plain ports.
 */
`timescale 1ns/1ps
// Contract
// R1: Master pulls select low before any serial clock pulse.
// R2: Master sends on MOSI, slave on MISO, both directions at once.
// R3: One 8-bit shift register moves a bit out and in per clock.
// R4: Data write loads shift register in normal mode, transmit buffer in buffered.
// R5: Data read returns first receive buffer normally, second when buffered.
// R6: As master the unit makes the serial clock itself.
// R7: As slave the incoming serial clock is synchronised and its edges used.
// R8: Enabled slave forces MOSI, SCK, SS to inputs; master forces MISO input.
// R9: Software-directed pins take unit output when output, plain input otherwise.
// R10: Slave MISO output drives while select low, floats while select high.
// R11: Unit runs during run-time debug but halts when the processor is halted.
// R12: Bit order selectable, LSB first or MSB first.
// R13: Master clock rates selectable, double speed reaching clock divided by two.
// R14: A finished byte exchange sets an end-of-transmission flag.
// R15: Writes colliding with a transfer set the write collision flag.
// R16: Transfers and the flag keep working during idle sleep.
// R17: Master write starts eight-bit transfer, done flag set after last bit.
// R18: Master with select input low becomes slave and sets done flag.
// R19: Normal-mode write during a transfer corrupts data and flags collision.
// R20: Slave with select high ignores clock pulses and captures nothing.
// R21: Role or bit-order change mid-transfer aborts it and restarts cleanly.
module spimsp_top
	import spimsp_pkg::*;
(
	// Clock and reset.
	input  wire logic              clock,
	input  wire logic              rst,
	// Software configuration and port directions.
	input  wire spimsp_cfg_t       cfg,
	input  wire spimsp_dir_t       portDir,
	input  wire logic              roleWrite,
	input  wire logic              roleWrData,
	// Software data access.
	input  wire logic              dataWrite,
	input  wire logic [DATA_W-1:0] wrData,
	input  wire logic              dataRead,
	output logic      [DATA_W-1:0] rdData_r,
	output logic                   rxAvail_r,
	output logic                   txEmpty_r,
	// Status.
	output logic                   masterRole_r,
	output logic                   doneFlag_r,
	output logic                   wrColFlag_r,
	input  wire logic              doneClr,
	input  wire logic              wrColClr,
	// Debug.
	input  wire logic              dbgHalt,
	input  wire logic              dbgRun,
	// Pins.
	input  wire logic              mosiIn,
	input  wire logic              misoIn,
	input  wire logic              sckIn,
	input  wire logic              ssIn,
	output spimsp_pin_t            mosiDrv_r,
	output spimsp_pin_t            misoDrv_r,
	output spimsp_pin_t            sckDrv_r,
	output spimsp_pin_t            ssDrv_r
);

	function automatic logic [DATA_W-1:0] shiftIn(input logic [DATA_W-1:0] s,
		input logic b, input logic lsb);
		shiftIn = lsb ? {b, s[DATA_W-1:1]} : {s[DATA_W-2:0], b}; // [R12]
	endfunction

	spimsp_state_t     state_r;
	spimsp_state_t     state_nxt;
	logic [6:0]        divCnt_r;
	logic [3:0]        phase_r;
	logic [3:0]        slvCnt_r;
	logic [DATA_W-1:0] sreg_r;
	logic [DATA_W-1:0] sreg_nxt;
	logic [DATA_W-1:0] txBuf_r;
	logic              txBufFull_r;
	logic [DATA_W-1:0] firstRx_r;
	logic              firstFull_r;
	logic              inLatch_r;
	logic              sckS1_r;
	logic              sckS2_r;
	logic              sckS3_r;
	logic [1:0]        cfgKey_r;
	logic              bufInReady;
	logic              bufOutValid;
	logic [DATA_W-1:0] bufOutData;

	// Idle sleep gates nothing here, so the unit finishes and flags while asleep. [R16]
	wire run      = !(dbgHalt && !dbgRun); // [R11]
	wire isMaster = masterRole_r && cfg.enable;
	wire isSlave  = !masterRole_r && cfg.enable;
	wire ssSense  = isMaster && !cfg.ssDisable && !portDir.ss;
	wire modeFault = run && ssSense && !ssIn; // [R18]
	wire abort    = (cfgKey_r != {masterRole_r, cfg.lsbFirst}); // [R21]

	wire [7:0] divSel  = PRESC_DIV[cfg.presc] >> cfg.clk2x; // [R13]
	wire [6:0] halfLen = divSel[7:1];
	wire       tick    = run && (state_r != ST_IDLE) && (divCnt_r == halfLen - 7'd1); // [R6]
	wire       mRise   = tick && (state_r == ST_SHIFT) && !phase_r[0];
	wire       mFall   = tick && (state_r == ST_SHIFT) && phase_r[0];
	wire       mDone   = mFall && (phase_r == LAST_PHASE); // [R17]

	wire sRise     = sckS2_r && !sckS3_r; // [R7]
	wire sFall     = !sckS2_r && sckS3_r;
	wire slvActive = run && isSlave && !ssIn; // [R20]
	wire slvRise   = slvActive && sRise;
	wire slvFall   = slvActive && sFall && (slvCnt_r != 4'h0);
	wire sDone     = slvRise && (slvCnt_r == LAST_BIT);

	wire               xferDone = (mDone || sDone) && !abort; // [R14]
	wire               inBit    = isMaster ? misoIn : mosiIn; // [R2]
	wire [DATA_W-1:0]  rxByte   = sDone ? shiftIn(sreg_r, inBit, cfg.lsbFirst)
	                                    : shiftIn(sreg_r, inLatch_r, cfg.lsbFirst);
	wire               outBit   = cfg.lsbFirst ? sreg_r[0] : sreg_r[DATA_W-1];
	// MOSI follows the next shift value, so it moves with the falling clock edge.
	wire               outNext  = cfg.lsbFirst ? sreg_nxt[0] : sreg_nxt[DATA_W-1];
	wire               busy     = (state_r != ST_IDLE) || (slvCnt_r != 4'h0);

	wire wrNormal = dataWrite && !cfg.bufMode;
	wire wrBuf    = dataWrite && cfg.bufMode && !txBufFull_r; // [R4]
	wire wrColSet = dataWrite && (cfg.bufMode ? txBufFull_r : busy); // [R15] [R19]
	wire startM   = isMaster && (state_r == ST_IDLE) && !abort &&
	                (cfg.bufMode ? (run && txBufFull_r && bufInReady) : wrNormal); // [R17]
	wire slvLoad  = run && isSlave && cfg.bufMode && txBufFull_r && (slvCnt_r == 4'h0) &&
	                !slvRise;
	wire bufLoad  = (startM && cfg.bufMode) || slvLoad;
	wire doneSet  = xferDone || modeFault; // [R18]
	wire bufPush  = xferDone && cfg.bufMode;
	wire bufPop   = dataRead && cfg.bufMode;

	spimsp_buf #(
		.WIDTH (DATA_W),
		.DEPTH (RXBUF_DEPTH)
	) u_rxBuf (
		.clock    (clock),
		.rst      (rst),
		.inValid  (bufPush),
		.inReady  (bufInReady),
		.inData   (rxByte),
		.outValid (bufOutValid),
		.outReady (bufPop),
		.outData  (bufOutData)
	);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (startM) begin
					state_nxt = ST_LEAD; // [R1]
				end
			end
			ST_LEAD: begin
				if (tick) begin
					state_nxt = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (mDone) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
		if (abort || !isMaster || modeFault) begin
			state_nxt = ST_IDLE; // [R21]
		end
	end

	always_comb begin
		sreg_nxt = sreg_r;
		if (wrNormal) begin
			sreg_nxt = wrData; // [R4] [R19]
		end else if (bufLoad) begin
			sreg_nxt = txBuf_r;
		end else if (xferDone) begin
			sreg_nxt = rxByte; // [R3]
		end else if (mFall || slvFall) begin
			sreg_nxt = shiftIn(sreg_r, inLatch_r, cfg.lsbFirst); // [R3]
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_r  <= ST_IDLE;
			divCnt_r <= 7'h00;
			phase_r  <= 4'h0;
			slvCnt_r <= 4'h0;
			cfgKey_r <= 2'h0;
		end else begin
			state_r  <= state_nxt;
			cfgKey_r <= {masterRole_r, cfg.lsbFirst};
			divCnt_r <= (state_r == ST_IDLE || tick) ? 7'h00 : (run ? divCnt_r + 7'd1 : divCnt_r);
			if (state_r != ST_SHIFT || abort) begin
				phase_r <= 4'h0;
			end else if (tick) begin
				phase_r <= phase_r + 4'h1;
			end
			if (!slvActive || abort || sDone) begin
				slvCnt_r <= 4'h0; // [R20]
			end else if (slvRise) begin
				slvCnt_r <= slvCnt_r + 4'h1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			sreg_r    <= SREG_RST;
			inLatch_r <= 1'b0;
			sckS1_r   <= 1'b0;
			sckS2_r   <= 1'b0;
			sckS3_r   <= 1'b0;
		end else begin
			sckS1_r <= sckIn;
			sckS2_r <= sckS1_r;
			sckS3_r <= sckS2_r;
			sreg_r  <= sreg_nxt;
			if (mRise || slvRise) begin
				inLatch_r <= inBit;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			txBuf_r      <= SREG_RST;
			txBufFull_r  <= 1'b0;
			firstRx_r    <= SREG_RST;
			firstFull_r  <= 1'b0;
			masterRole_r <= 1'b0;
			doneFlag_r   <= 1'b0;
			wrColFlag_r  <= 1'b0;
		end else begin
			if (wrBuf) begin
				txBuf_r <= wrData;
			end
			txBufFull_r <= wrBuf || (txBufFull_r && !bufLoad);
			if (xferDone && !cfg.bufMode) begin
				firstRx_r <= rxByte;
			end
			firstFull_r  <= (xferDone && !cfg.bufMode) || (firstFull_r && !dataRead);
			masterRole_r <= modeFault ? 1'b0 : (roleWrite ? roleWrData : masterRole_r);
			doneFlag_r   <= doneSet || (doneFlag_r && !doneClr);
			wrColFlag_r  <= wrColSet || (wrColFlag_r && !wrColClr);
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rdData_r  <= SREG_RST;
			rxAvail_r <= 1'b0;
			txEmpty_r <= 1'b1;
			mosiDrv_r <= '0;
			misoDrv_r <= '0;
			sckDrv_r  <= '0;
			ssDrv_r   <= '{out: 1'b1, oe: 1'b0};
		end else begin
			rdData_r  <= cfg.bufMode ? bufOutData : firstRx_r; // [R5]
			rxAvail_r <= cfg.bufMode ? bufOutValid : firstFull_r;
			txEmpty_r <= !txBufFull_r;
			mosiDrv_r <= '{out: outNext, oe: isMaster && portDir.mosi}; // [R8] [R9]
			sckDrv_r  <= '{out: mRise || (sckDrv_r.out && !mFall && state_r == ST_SHIFT),
			               oe: isMaster && portDir.sck}; // [R6] [R8]
			ssDrv_r   <= '{out: (state_r == ST_IDLE), oe: isMaster && portDir.ss}; // [R1]
			misoDrv_r <= '{out: outBit, oe: isSlave && portDir.miso && !ssIn}; // [R10]
		end
	end

	// Helper count of master clock rises within one transfer.
	logic [3:0] riseCnt_r;
	always_ff @(posedge clock) begin
		if (rst || startM) begin
			riseCnt_r <= 4'h0;
		end else if (mRise) begin
			riseCnt_r <= riseCnt_r + 4'h1;
		end
	end

	sequence s_sckPulse;
		$rose(sckDrv_r.out) ##1 $fell(sckDrv_r.out);
	endsequence

	a_select_before_clock: assert property (@(posedge clock) disable iff (rst) // [R1]
		$rose(sckDrv_r.out) |-> !ssDrv_r.out && $past(!ssDrv_r.out))
		else $error("serial clock rose without select held low");
	a_mosi_stable_high: assert property (@(posedge clock) disable iff (rst) // [R2]
		(sckDrv_r.out && $past(sckDrv_r.out)) |-> $stable(mosiDrv_r.out))
		else $error("MOSI changed while serial clock high");
	a_eight_bit_done: assert property (@(posedge clock) disable iff (rst) // [R17]
		(mDone && !abort) |-> (riseCnt_r == BIT_COUNT) ##1 doneFlag_r)
		else $error("master transfer did not finish after eight bits");
	a_slave_pins_input: assert property (@(posedge clock) disable iff (rst) // [R8]
		isSlave |=> !mosiDrv_r.oe && !sckDrv_r.oe && !ssDrv_r.oe)
		else $error("slave drove an input-only pin");
	a_miso_tristate: assert property (@(posedge clock) disable iff (rst) // [R10]
		(isSlave && portDir.miso) |=> (misoDrv_r.oe == !$past(ssIn)))
		else $error("slave MISO enable does not follow select");
	a_mode_fault: assert property (@(posedge clock) disable iff (rst) // [R18]
		modeFault |=> !masterRole_r && doneFlag_r && state_r == ST_IDLE)
		else $error("select low did not demote the master");
	a_write_collision: assert property (@(posedge clock) disable iff (rst) // [R19]
		(wrNormal && busy) |=> wrColFlag_r && sreg_r == $past(wrData))
		else $error("collision write not flagged");
	a_halt_freeze: assert property (@(posedge clock) disable iff (rst) // [R11]
		(!run && !dataWrite && !roleWrite && !abort) |=> $stable(sreg_r) && $stable(phase_r))
		else $error("unit moved while processor halted");
	a_double_speed: assert property (@(posedge clock) disable iff (rst) // [R13]
		(cfg.clk2x && cfg.presc == 2'b00 && run && !abort && mRise) ##1
		(cfg.clk2x && cfg.presc == 2'b00 && run && !abort) |-> s_sckPulse)
		else $error("double speed clock is not half the peripheral clock");
	a_done_set_wins: assert property (@(posedge clock) disable iff (rst) // [R14]
		(doneSet && doneClr) |=> doneFlag_r)
		else $error("done flag lost to a simultaneous clear");
	a_slave_ignore: assert property (@(posedge clock) disable iff (rst) // [R20]
		(isSlave && ssIn) |=> slvCnt_r == 4'h0 && $stable(inLatch_r))
		else $error("deselected slave reacted to the clock");

endmodule

// ### verification/spimsp_peer.sv
/*
 * Far-side party of the serial port: a slave that answers frames from the unit
 * and a master task that runs frames against it, both in clock mode 0.
 * Assumes the bench resolves the lines, with pull-ups and a pull-down on SCK.
 */
`timescale 1ns/1ps
module spimsp_peer
	import spimsp_pkg::*;
(
	// Bench clock and settings.
	input  wire logic       clock,
	input  wire logic       lsb,
	input  wire logic [7:0] txByte,
	// Resolved lines.
	input  wire logic       sckLine,
	input  wire logic       ssLine,
	input  wire logic       mosiLine,
	input  wire logic       misoLine,
	// Peer drives.
	output spimsp_pin_t     pSck,
	output spimsp_pin_t     pSs,
	output spimsp_pin_t     pMosi,
	output spimsp_pin_t     pMiso,
	output logic      [7:0] rxByte
);
	logic [7:0] sh;
	logic [7:0] acc;
	logic       busyM = 1'b0;
	int         n;
	event       got;
	initial begin
		pSck = '{1'b0, 1'b0};
		pSs = '{1'b1, 1'b0};
		pMosi = '{1'b1, 1'b0};
		pMiso = '{1'b1, 1'b0};
	end
	function automatic logic firstBit(input logic [7:0] v);
		return lsb ? v[0] : v[7];
	endfunction
	// Slave half: data is shifted only while the frame is selected.
	always @(negedge ssLine) if (!busyM) begin
		sh = txByte;
		n = 0;
		pMiso = '{firstBit(txByte), 1'b1};
	end
	always @(posedge ssLine) pMiso.oe = 1'b0;
	always @(posedge sckLine) if (!busyM && !ssLine) begin
		acc = lsb ? {mosiLine, acc[7:1]} : {acc[6:0], mosiLine};
		n++;
		if (n == 8) begin
			rxByte = acc;
			->got;
		end
	end
	always @(negedge sckLine) if (!busyM && !ssLine) begin
		sh = lsb ? sh >> 1 : sh << 1;
		pMiso.out = firstBit(sh);
	end
	// Master half: each clock half lasts six cycles, above the unit's sampling need.
	task automatic xfer(input logic [7:0] b, input logic sel);
		busyM = 1'b1;
		sh = b;
		@(negedge clock);
		pSs = '{!sel, 1'b1};
		pMosi = '{firstBit(b), 1'b1};
		pSck.oe = 1'b1;
		repeat (6) @(negedge clock);
		for (int i = 0; i < 8; i++) begin
			pSck.out = 1'b1;
			acc = lsb ? {misoLine, acc[7:1]} : {acc[6:0], misoLine};
			repeat (6) @(negedge clock);
			pSck.out = 1'b0;
			sh = lsb ? sh >> 1 : sh << 1;
			pMosi.out = firstBit(sh);
			repeat (6) @(negedge clock);
		end
		pSs.out = 1'b1;
		rxByte = acc;
		if (sel) ->got;
		@(negedge clock);
		pSs.oe = 1'b0;
		pMosi.oe = 1'b0;
		pSck.oe = 1'b0;
		busyM = 1'b0;
	endtask
	task automatic selPulse();
		busyM = 1'b1;
		@(negedge clock);
		pSs = '{1'b0, 1'b1};
		repeat (4) @(negedge clock);
		pSs.out = 1'b1;
		@(negedge clock);
		pSs.oe = 1'b0;
		busyM = 1'b0;
	endtask
endmodule

// ### verification/spimsp_top_tb.sv
/*
 * Self-checking bench for the serial port: master and slave frames, rates,
 * bit orders, collision, mode fault, debug halt and buffered receive.
 * Assumes the peer model in its own file, pulled-up lines and a pulled-down SCK.
 */
`timescale 1ns/1ps
module spimsp_top_tb;
	import spimsp_pkg::*;
	logic              clock = 1'b0;
	logic              rst = 1'b1;
	spimsp_cfg_t       cfg = '0;
	spimsp_dir_t       portDir = '0;
	logic              roleWrite = 1'b0;
	logic              roleWrData = 1'b0;
	logic              dataWrite = 1'b0;
	logic [DATA_W-1:0] wrData = '0;
	logic              dataRead = 1'b0;
	logic              doneClr = 1'b0;
	logic              wrColClr = 1'b0;
	logic              dbgHalt = 1'b0;
	logic              dbgRun = 1'b1;
	logic [DATA_W-1:0] rdData_r;
	logic              rxAvail_r, txEmpty_r, masterRole_r, doneFlag_r, wrColFlag_r;
	spimsp_pin_t       mosiDrv_r, misoDrv_r, sckDrv_r, ssDrv_r;
	spimsp_pin_t       pSck, pSs, pMosi, pMiso;
	logic [7:0]        peerTx = '0;
	logic [7:0]        peerRx;
	logic [7:0]        peerQ[$];
	logic [7:0]        devQ[$];
	logic [7:0]        b;
	logic [7:0]        v[3];
	int                n_fail = 0;
	int                num_checks = 0;
	int                expH = 0;
	int                hiCnt = 0;
	int                seed = 32'h3e56_0cf8;
	wire logic sckLine = sckDrv_r.oe ? sckDrv_r.out : (pSck.oe ? pSck.out : 1'b0);
	wire logic ssLine = ssDrv_r.oe ? ssDrv_r.out : (pSs.oe ? pSs.out : 1'b1);
	wire logic mosiLine = mosiDrv_r.oe ? mosiDrv_r.out : (pMosi.oe ? pMosi.out : 1'b1);
	wire logic misoLine = misoDrv_r.oe ? misoDrv_r.out : (pMiso.oe ? pMiso.out : 1'b1);
	always #10 clock = ~clock;
	spimsp_top uut (.clock(clock), .rst(rst), .cfg(cfg), .portDir(portDir),
		.roleWrite(roleWrite), .roleWrData(roleWrData), .dataWrite(dataWrite),
		.wrData(wrData), .dataRead(dataRead), .rdData_r(rdData_r), .rxAvail_r(rxAvail_r),
		.txEmpty_r(txEmpty_r), .masterRole_r(masterRole_r), .doneFlag_r(doneFlag_r),
		.wrColFlag_r(wrColFlag_r), .doneClr(doneClr), .wrColClr(wrColClr),
		.dbgHalt(dbgHalt), .dbgRun(dbgRun), .mosiIn(mosiLine), .misoIn(misoLine),
		.sckIn(sckLine), .ssIn(ssLine), .mosiDrv_r(mosiDrv_r), .misoDrv_r(misoDrv_r),
		.sckDrv_r(sckDrv_r), .ssDrv_r(ssDrv_r));
	spimsp_peer peer (.clock(clock), .lsb(cfg.lsbFirst), .txByte(peerTx),
		.sckLine(sckLine), .ssLine(ssLine), .mosiLine(mosiLine), .misoLine(misoLine),
		.pSck(pSck), .pSs(pSs), .pMosi(pMosi), .pMiso(pMiso), .rxByte(peerRx));
	task automatic chkByte(input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	task automatic chkBit(input logic e, input logic g);
		chkByte({7'h00, e}, {7'h00, g});
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge clock);
	endtask
	task automatic setCfg(input logic bm, lf, c2, input logic [1:0] pr, input logic sd);
		@(negedge clock);
		cfg = '{1'b1, bm, lf, c2, pr, sd};
	endtask
	task automatic role(input logic m);
		@(negedge clock);
		roleWrite = 1'b1;
		roleWrData = m;
		@(negedge clock);
		roleWrite = 1'b0;
	endtask
	task automatic wr(input logic [7:0] d);
		@(negedge clock);
		dataWrite = 1'b1;
		wrData = d;
		@(negedge clock);
		dataWrite = 1'b0;
	endtask
	task automatic rd();
		@(negedge clock);
		dataRead = 1'b1;
		@(negedge clock);
		dataRead = 1'b0;
		cyc(2);
	endtask
	task automatic waitDone(input int lim);
		int k;
		k = 0;
		while (doneFlag_r !== 1'b1 && k < lim) begin
			@(negedge clock);
			k++;
		end
		chkBit(1'b1, doneFlag_r);
		cyc(3);
		doneClr = 1'b1;
		@(negedge clock);
		doneClr = 1'b0;
	endtask
	task automatic masterByte(input int lim);
		peerTx = 8'($random(seed));
		b = 8'($random(seed));
		peerQ.push_back(b);
		devQ.push_back(peerTx);
		wr(b);
	endtask
	// Scoreboard: notes are taken off the queues as the results appear.
	// The peer's byte reaches its port in the same step as the event, so look one unit later.
	always @(peer.got) if (peerQ.size() > 0) begin
		#1;
		chkByte(peerQ.pop_front(), peerRx);
	end
	always @(posedge doneFlag_r) if (devQ.size() > 0) begin
		repeat (2) @(negedge clock);
		chkByte(devQ.pop_front(), rdData_r);
	end
	always @(posedge sckLine) if (sckDrv_r.oe === 1'b1) chkBit(1'b0, ssLine);
	always @(negedge clock) begin
		if (sckDrv_r.oe === 1'b1 && sckDrv_r.out === 1'b1) hiCnt++;
		else begin
			if (hiCnt > 0 && expH > 0) chkByte(8'(expH), 8'(hiCnt));
			hiCnt = 0;
		end
	end
	initial begin
		cyc(60000);
		n_fail++;
		tally_and_finish();
	end
	initial begin
		cyc(10);
		rst = 1'b0;
		cyc(1);
		chkBit(1'b1, txEmpty_r);
		chkBit(1'b0, masterRole_r | doneFlag_r | wrColFlag_r | rxAvail_r);
		portDir = '{1'b1, 1'b1, 1'b1, 1'b1};
		for (int i = 0; i < 8; i++) begin
			setCfg(1'b0, i[0] ^ i[2], i[2], i[1:0], 1'b1);
			expH = int'(PRESC_DIV[i[1:0]] >> i[2]) / 2;
			dbgHalt = i[1];
			role(1'b1);
			chkBit(1'b0, misoDrv_r.oe);
			masterByte(0);
			waitDone(40 * expH + 60);
		end
		setCfg(1'b0, 1'b0, 1'b1, 2'b00, 1'b1);
		expH = 1;
		dbgHalt = 1'b1;
		dbgRun = 1'b0;
		masterByte(0);
		cyc(100);
		chkBit(1'b0, doneFlag_r);
		dbgHalt = 1'b0;
		dbgRun = 1'b1;
		waitDone(200);
		setCfg(1'b0, 1'b0, 1'b0, 2'b11, 1'b1);
		expH = 64;
		masterByte(0);
		peerQ.delete();
		peerQ.push_back(8'h3c);
		cyc(30);
		wr(8'h3c);
		cyc(2);
		chkBit(1'b1, wrColFlag_r);
		waitDone(3000);
		wrColClr = 1'b1;
		cyc(1);
		wrColClr = 1'b0;
		cyc(1);
		chkBit(1'b0, wrColFlag_r);
		setCfg(1'b0, 1'b0, 1'b0, 2'b00, 1'b0);
		portDir.ss = 1'b0;
		role(1'b1);
		peer.selPulse();
		cyc(2);
		chkBit(1'b0, masterRole_r);
		waitDone(5);
		portDir = '{1'b1, 1'b1, 1'b1, 1'b1};
		expH = 0;
		role(1'b0);
		cyc(2);
		chkBit(1'b0, mosiDrv_r.oe | sckDrv_r.oe | ssDrv_r.oe);
		chkBit(1'b0, misoDrv_r.oe);
		peer.xfer(8'h5a, 1'b0);
		cyc(5);
		chkBit(1'b0, doneFlag_r);
		for (int i = 0; i < 2; i++) begin
			setCfg(1'b0, i[0], 1'b0, 2'b00, 1'b1);
			b = 8'($random(seed));
			wr(b);
			peerQ.push_back(b);
			v[0] = 8'($random(seed));
			devQ.push_back(v[0]);
			peer.xfer(v[0], 1'b1);
			waitDone(50);
		end
		setCfg(1'b1, 1'b0, 1'b0, 2'b00, 1'b1);
		for (int i = 0; i < 3; i++) begin
			v[i] = 8'($random(seed));
			peer.xfer(v[i], 1'b1);
		end
		cyc(4);
		chkBit(1'b1, rxAvail_r);
		chkByte(v[0], rdData_r);
		rd();
		chkByte(v[1], rdData_r);
		rd();
		chkBit(1'b0, rxAvail_r);
		waitDone(5);
		setCfg(1'b1, 1'b0, 1'b0, 2'b01, 1'b1);
		expH = 8;
		role(1'b1);
		masterByte(0);
		waitDone(400);
		chkBit(1'b1, txEmpty_r);
		tally_and_finish();
	end
endmodule
